/* File: ssp_pkg.sv */
// Package with register map, field positions, mode codes and state encodings of the serial port
package ssp_pkg;
    // Register byte addresses
    localparam logic [4:0] OFS_CTRL1 = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RELOAD = 5'h08;
    localparam logic [4:0] OFS_BUFFER = 5'h0C;
    localparam logic [4:0] OFS_CTRL2 = 5'h10;
    localparam logic [4:0] OFS_FLAGS = 5'h14;
    // Field positions
    localparam int C1_WRITE_COLLISION_FLAG = 7;
    localparam int C1_OVF = 6;
    localparam int C1_EN = 5;
    localparam int C1_CKP = 4;
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_STOP = 4;
    localparam int ST_START = 3;
    localparam int ST_RW = 2;
    localparam int ST_BF = 0;
    localparam int C2_STOP_REQ = 2;
    localparam int FL_BCOL = 1;
    localparam int FL_EVT = 0;
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] BUFFER_RST = 8'h00;
    // Port mode codes
    localparam logic [3:0] MODE_SPI_DIV4 = 4'h0;
    localparam logic [3:0] MODE_SPI_DIV16 = 4'h1;
    localparam logic [3:0] MODE_SPI_DIV64 = 4'h2;
    localparam logic [3:0] MODE_SPI_TMR = 4'h3;
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_RELOAD = 4'hA;
    // Fixed reload values that give Fosc/4, Fosc/16 and Fosc/64
    localparam logic [7:0] RLD_DIV4 = 8'h00;
    localparam logic [7:0] RLD_DIV16 = 8'h03;
    localparam logic [7:0] RLD_DIV64 = 8'h0F;
    // Last half period of an eight bit SPI transfer
    localparam logic [3:0] SPI_LAST_HALF = 4'hF;

    typedef enum logic [2:0] {
        STP_IDLE = 3'b000,
        STP_SDA_LOW = 3'b001,
        STP_SCL_REL = 3'b011,
        STP_SCL_HIGH = 3'b010,
        STP_SDA_REL = 3'b110,
        STP_DONE = 3'b100
    } ssp_stop_e;

    function automatic logic is_i2c(input logic [3:0] mode);
        is_i2c = (mode == 4'h6) || (mode == 4'h7) || (mode == 4'h8) || (mode == 4'hB)
            || (mode == 4'hE) || (mode == 4'hF);
    endfunction : is_i2c

    function automatic logic is_spi_master(input logic [3:0] mode);
        is_spi_master = (mode <= MODE_SPI_TMR) || (mode == MODE_SPI_RELOAD);
    endfunction : is_spi_master

    // Reload value the divider uses in the given mode
    function automatic logic [7:0] div_reload(input logic [3:0] mode, input logic [7:0] rld);
        case (mode)
            MODE_SPI_DIV16: div_reload = RLD_DIV16;
            MODE_SPI_DIV64: div_reload = RLD_DIV64;
            MODE_SPI_DIV4, MODE_SPI_TMR: div_reload = RLD_DIV4;
            default: div_reload = rld;
        endcase
    endfunction : div_reload
endpackage : ssp_pkg

/* File: ssp_divider.sv */
// Shared clock divider: counts down from the reload value at half the clock rate
`timescale 1ns/1ps
module ssp_divider #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic run,
    input wire logic [W-1:0] reload,
    output logic tick
);
    logic [W-1:0] count_reg;
    logic phase_reg;

    // Count moves every second clock, so a rollover spans 2*(reload+1) clocks
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_reg <= '0;
            phase_reg <= 1'b0;
        end else if (load) begin
            count_reg <= reload;
            phase_reg <= 1'b0;
        end else if (run) begin
            phase_reg <= ~phase_reg;
            if (phase_reg) begin
                count_reg <= (count_reg == '0) ? reload : count_reg - 1'b1;
            end
        end
    end

    // Rollover pulse; the counter reloads itself on it
    assign tick = run && phase_reg && (count_reg == '0);
endmodule : ssp_divider

/* File: ssp_port.sv */
// Serial port core: register slave, SPI master engine, I2C stop sequence and bus monitor
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Stop: data low after release timeout collides
// - Stop: clock low before data high collides
// - Stop: data low, release clock, then count
// - Shift buffer write starts the divider (SPI master only; in I2C master the write only queues the byte)
// - Divider stops when the operation ends
// - Divider reloads twice per clock period
// - Clock equals Fosc over four times reload+1
// - Sample bit picks end or middle sampling
// - Clock edge bit picks SPI transmit edge
// - Clock edge bit selects SMBus levels in I2C
// - Stop-seen shows last condition was Stop
// - Reset or disable clears Stop/Start seen
// - Read/write bit shows transmit in progress
// - Enable hands serial pins to the port
// - Collision sets flag, port returns idle
// - Period after Stop seen, clear request, event
// - Buffer write while busy sets write collision
module ssp_port (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    input wire logic spi_data_in_pin,
    output logic port_pins_owned,
    output logic smbus_levels
);
    logic [7:0] ctrl1_reg, status_reg, reload_reg, buffer_reg;
    logic stop_req_reg, bcol_reg, evt_reg, write_collision_flag_reg, bf_reg, i2c_tx_reg;
    logic stop_seen_reg, start_seen_reg;
    logic [1:0] sda_sync, scl_sync, sdi_sync;
    logic sda_prev, scl_prev;
    ssp_pkg::ssp_stop_e stop_st;
    logic sda_pull_reg, scl_pull_reg;
    logic spi_busy_reg, sclk_reg;
    logic [3:0] half_reg;
    logic [7:0] tx_reg, rx_reg, rx_next;
    logic [31:0] rd_word;
    logic acc_wr, acc_rd, buf_wr, busy, spi_start, spi_done, tick, div_load, div_run;
    logic en, clock_polarity_bit, sample_phase_bit, cke, i2c, i2c_master, spi_master;
    logic going_active, shift_e, sample, stop_coll, stop_done;
    logic stop_ev, start_ev;

    assign en = ctrl1_reg[ssp_pkg::C1_EN];
    assign clock_polarity_bit = ctrl1_reg[ssp_pkg::C1_CKP];
    assign sample_phase_bit = status_reg[ssp_pkg::ST_SMP];
    assign cke = status_reg[ssp_pkg::ST_CKE];
    assign i2c = ssp_pkg::is_i2c(ctrl1_reg[3:0]);
    assign i2c_master = en && (ctrl1_reg[3:0] == ssp_pkg::MODE_I2C_MASTER);
    assign spi_master = en && ssp_pkg::is_spi_master(ctrl1_reg[3:0]);

    // Pins come from another domain: two flops before any use
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sda_sync <= 2'b11;
            scl_sync <= 2'b11;
            sdi_sync <= 2'b00;
            sda_prev <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            sda_sync <= {sda_sync[0], serial_data_line_in};
            scl_sync <= {scl_sync[0], serial_clock_line_in};
            sdi_sync <= {sdi_sync[0], spi_data_in_pin};
            sda_prev <= sda_sync[1];
            scl_prev <= scl_sync[1];
        end
    end

    // Bus access: one wait cycle, answer on the cycle waitrequest is low
    assign acc_wr = avs_write && !avs_waitrequest;
    assign acc_rd = avs_read && !avs_waitrequest;
    assign buf_wr = acc_wr && avs_byteenable[0] && (avs_address[4:2] == ssp_pkg::OFS_BUFFER[4:2]);
    assign busy = spi_busy_reg || (stop_st != ssp_pkg::STP_IDLE) || i2c_tx_reg;
    assign spi_start = buf_wr && !busy && spi_master;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address[4:2])
            ssp_pkg::OFS_CTRL1[4:2]: begin
                rd_word[7:0] = {write_collision_flag_reg, 1'b0, ctrl1_reg[5:0]};
            end
            ssp_pkg::OFS_STATUS[4:2]: begin
                rd_word[7:0] = {sample_phase_bit, cke, 1'b0, stop_seen_reg, start_seen_reg,
                    i2c_master && i2c_tx_reg, 1'b0, bf_reg};
            end
            ssp_pkg::OFS_RELOAD[4:2]: rd_word[7:0] = reload_reg;
            ssp_pkg::OFS_BUFFER[4:2]: rd_word[7:0] = buffer_reg;
            ssp_pkg::OFS_CTRL2[4:2]: rd_word[ssp_pkg::C2_STOP_REQ] = stop_req_reg;
            ssp_pkg::OFS_FLAGS[4:2]: rd_word[1:0] = {bcol_reg, evt_reg};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Software-owned configuration registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl1_reg <= ssp_pkg::CTRL1_RST;
            status_reg <= ssp_pkg::STATUS_RST;
            reload_reg <= ssp_pkg::RELOAD_RST;
        end else if (acc_wr && avs_byteenable[0]) begin
            case (avs_address[4:2])
                ssp_pkg::OFS_CTRL1[4:2]: ctrl1_reg <= {2'b00, avs_writedata[5:0]};
                ssp_pkg::OFS_STATUS[4:2]: status_reg <= {avs_writedata[7:6], 6'b000000};
                ssp_pkg::OFS_RELOAD[4:2]: reload_reg <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Write collision: cleared by writing zero, a new collision wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            write_collision_flag_reg <= 1'b0;
        end else if (buf_wr && busy) begin
            write_collision_flag_reg <= 1'b1;
        end else if (acc_wr && avs_byteenable[0] && avs_address[4:2] == ssp_pkg::OFS_CTRL1[4:2]
            && !avs_writedata[ssp_pkg::C1_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_reg <= 1'b0;
        end
    end

    // Shift buffer and buffer-full flag; a refused write leaves the buffer alone
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buffer_reg <= ssp_pkg::BUFFER_RST;
            bf_reg <= 1'b0;
        end else begin
            if (spi_done) begin
                buffer_reg <= rx_next;
            end else if (buf_wr && !busy) begin
                buffer_reg <= avs_writedata[7:0];
            end
            if (spi_done) begin
                bf_reg <= 1'b1;
            end else if (acc_rd && avs_address[4:2] == ssp_pkg::OFS_BUFFER[4:2]) begin
                bf_reg <= 1'b0;
            end
        end
    end

    // Byte queued for the I2C transmitter; dropped by collision or Stop
    always_ff @(posedge ref_clk) begin
        if (srst || !i2c_master || stop_coll || stop_st != ssp_pkg::STP_IDLE) begin
            i2c_tx_reg <= 1'b0;
        end else if (buf_wr && !busy) begin
            i2c_tx_reg <= 1'b1;
        end
    end

    // Shared divider: only runs while a transfer or Stop sequence needs it
    assign div_load = spi_start || (stop_st == ssp_pkg::STP_SCL_REL && scl_sync[1]);
    assign div_run = spi_busy_reg || stop_st == ssp_pkg::STP_SCL_HIGH
        || stop_st == ssp_pkg::STP_SDA_REL || stop_st == ssp_pkg::STP_DONE;

    ssp_divider #(
        .W(8)
    ) u_div (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(div_load),
        .run(div_run),
        .reload(ssp_pkg::div_reload(ctrl1_reg[3:0], reload_reg)),
        .tick(tick)
    );

    // SPI edges: each rollover is one clock edge, two per period
    assign going_active = (sclk_reg == clock_polarity_bit);
    assign shift_e = cke ? !going_active : going_active;
    assign sample = sample_phase_bit ? ((shift_e && half_reg != 4'h0) || (half_reg == ssp_pkg::SPI_LAST_HALF
        && !cke)) : !shift_e;
    assign rx_next = sample ? {rx_reg[6:0], sdi_sync[1]} : rx_reg;
    assign spi_done = spi_busy_reg && tick && (half_reg == ssp_pkg::SPI_LAST_HALF);

    // SPI master engine; first bit is presented before the first edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            spi_busy_reg <= 1'b0;
            half_reg <= 4'h0;
            sclk_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
        end else if (!spi_master) begin
            spi_busy_reg <= 1'b0;
            sclk_reg <= clock_polarity_bit;
        end else if (spi_start) begin
            spi_busy_reg <= 1'b1;
            half_reg <= 4'h0;
            tx_reg <= avs_writedata[7:0];
            sclk_reg <= clock_polarity_bit;
        end else if (spi_busy_reg && tick) begin
            sclk_reg <= ~sclk_reg;
            half_reg <= half_reg + 4'h1;
            rx_reg <= rx_next;
            if (shift_e && half_reg != 4'h0) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
            if (half_reg == ssp_pkg::SPI_LAST_HALF) begin
                spi_busy_reg <= 1'b0;
            end
        end else if (!spi_busy_reg) begin
            sclk_reg <= clock_polarity_bit;
        end
    end

    // Stop sequence; a collision drops both lines and the request at once
    assign stop_coll = ((stop_st == ssp_pkg::STP_SCL_HIGH || stop_st == ssp_pkg::STP_SDA_REL)
        && !scl_sync[1] && !sda_sync[1])
        || (stop_st == ssp_pkg::STP_SCL_HIGH && !scl_sync[1])
        || (stop_st == ssp_pkg::STP_SDA_REL && tick && !sda_sync[1]);
    assign stop_done = (stop_st == ssp_pkg::STP_DONE) && tick;

    always_ff @(posedge ref_clk) begin
        if (srst || !i2c_master || stop_coll) begin
            stop_st <= ssp_pkg::STP_IDLE;
            sda_pull_reg <= 1'b0;
            scl_pull_reg <= 1'b0;
        end else begin
            case (stop_st)
                ssp_pkg::STP_IDLE: begin
                    if (stop_req_reg) begin
                        stop_st <= ssp_pkg::STP_SDA_LOW;
                        sda_pull_reg <= 1'b1;
                        scl_pull_reg <= 1'b1;
                    end
                end
                ssp_pkg::STP_SDA_LOW: begin
                    if (!sda_sync[1] && !scl_sync[1]) begin // Stale clock high must not skip
                        stop_st <= ssp_pkg::STP_SCL_REL;
                        scl_pull_reg <= 1'b0;
                    end
                end
                ssp_pkg::STP_SCL_REL: begin
                    if (scl_sync[1]) begin
                        stop_st <= ssp_pkg::STP_SCL_HIGH;
                    end
                end
                ssp_pkg::STP_SCL_HIGH: begin
                    if (tick) begin
                        stop_st <= ssp_pkg::STP_SDA_REL;
                        sda_pull_reg <= 1'b0;
                    end
                end
                ssp_pkg::STP_SDA_REL: begin
                    if (tick) begin
                        stop_st <= ssp_pkg::STP_DONE;
                    end
                end
                ssp_pkg::STP_DONE: begin
                    if (tick) begin
                        stop_st <= ssp_pkg::STP_IDLE;
                    end
                end
                default: stop_st <= ssp_pkg::STP_IDLE;
            endcase
        end
    end

    // Stop request: set only when idle, cleared by hardware at the end
    always_ff @(posedge ref_clk) begin
        if (srst || !i2c_master || stop_coll || stop_done) begin
            stop_req_reg <= 1'b0;
        end else if (acc_wr && avs_byteenable[0] && avs_address[4:2] == ssp_pkg::OFS_CTRL2[4:2]
            && avs_writedata[ssp_pkg::C2_STOP_REQ] && !busy && !stop_req_reg) begin
            stop_req_reg <= 1'b1;
        end
    end

    // Event and collision flags: write one to clear, a new event wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bcol_reg <= 1'b0;
            evt_reg <= 1'b0;
        end else begin
            if (stop_coll) begin
                bcol_reg <= 1'b1;
            end else if (acc_wr && avs_byteenable[0] && avs_address[4:2] ==
                ssp_pkg::OFS_FLAGS[4:2] && avs_writedata[ssp_pkg::FL_BCOL]) begin
                bcol_reg <= 1'b0;
            end
            if (stop_done || spi_done) begin
                evt_reg <= 1'b1;
            end else if (acc_wr && avs_byteenable[0] && avs_address[4:2] ==
                ssp_pkg::OFS_FLAGS[4:2] && avs_writedata[ssp_pkg::FL_EVT]) begin
                evt_reg <= 1'b0;
            end
        end
    end

    // Bus monitor sees Start and Stop from any master on the lines
    assign stop_ev = scl_sync[1] && scl_prev && sda_sync[1] && !sda_prev;
    assign start_ev = scl_sync[1] && scl_prev && !sda_sync[1] && sda_prev;

    always_ff @(posedge ref_clk) begin
        if (srst || !en || !i2c) begin
            stop_seen_reg <= 1'b0;
            start_seen_reg <= 1'b0;
        end else if (stop_ev) begin
            stop_seen_reg <= 1'b1;
            start_seen_reg <= 1'b0;
        end else if (start_ev) begin
            stop_seen_reg <= 1'b0;
            start_seen_reg <= 1'b1;
        end
    end

    // Pin ownership; I2C lines are open drain, SPI lines push-pull
    always_ff @(posedge ref_clk) begin
        if (srst || !en) begin
            serial_data_line_out <= 1'b0;
            serial_data_line_oe <= 1'b0;
            serial_clock_line_out <= 1'b0;
            serial_clock_line_oe <= 1'b0;
        end else if (i2c) begin
            serial_data_line_out <= 1'b0;
            serial_data_line_oe <= sda_pull_reg;
            serial_clock_line_out <= 1'b0;
            serial_clock_line_oe <= scl_pull_reg;
        end else begin
            serial_data_line_out <= tx_reg[7];
            serial_data_line_oe <= spi_master;
            serial_clock_line_out <= sclk_reg;
            serial_clock_line_oe <= spi_master;
        end
    end

    // Status outputs; SMBus thresholds only mean something in I2C mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_pins_owned <= 1'b0;
            smbus_levels <= 1'b0;
        end else begin
            port_pins_owned <= en;
            smbus_levels <= en && i2c && cke;
        end
    end

    // Helper: cycles since last rollover, for the period check
    logic [9:0] gap_cnt;
    always_ff @(posedge ref_clk) begin
        if (srst || div_load || tick || !div_run) begin
            gap_cnt <= 10'h000;
        end else begin
            gap_cnt <= gap_cnt + 10'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_stop_data_coll: assert property (stop_st == ssp_pkg::STP_SDA_REL && tick && !sda_sync[1]
        |=> bcol_reg && stop_st == ssp_pkg::STP_IDLE && !stop_req_reg)
        else $error("stop data collision missed");
    a_stop_clk_coll: assert property (stop_st == ssp_pkg::STP_SCL_HIGH && !scl_sync[1]
        |=> bcol_reg ##1 !serial_clock_line_oe && !serial_data_line_oe)
        else $error("stop clock collision missed");
    a_stop_release: assert property (stop_st == ssp_pkg::STP_SDA_LOW && !sda_sync[1]
        && !scl_sync[1] && i2c_master
        |=> stop_st == ssp_pkg::STP_SCL_REL ##1 !serial_clock_line_oe)
        else $error("clock not released in stop");
    a_write_starts: assert property (spi_start |=> spi_busy_reg && div_run)
        else $error("buffer write did not start divider");
    a_div_idle: assert property (!spi_busy_reg && stop_st == ssp_pkg::STP_IDLE |-> !tick)
        else $error("divider runs while idle");
    a_div_period: assert property (tick && gap_cnt != 10'h000 |-> gap_cnt == 10'(2 *
        ssp_pkg::div_reload(ctrl1_reg[3:0], reload_reg) + 1))
        else $error("divider period wrong");
    a_spi_edge: assert property (spi_busy_reg && tick && spi_master
        |=> ##1 serial_clock_line_out != $past(serial_clock_line_out, 2))
        else $error("spi clock did not toggle");
    a_smbus_lvl: assert property (en && i2c |=> smbus_levels == $past(cke))
        else $error("smbus levels wrong");
    a_seen_clear: assert property (!en |=> !stop_seen_reg && !start_seen_reg)
        else $error("seen bits not cleared");
    a_stop_end: assert property (stop_done && i2c_master |=> !stop_req_reg && evt_reg)
        else $error("stop end not signalled");
    a_write_collision_flag_keep: assert property (buf_wr && busy && !spi_done
        |=> write_collision_flag_reg && buffer_reg == $past(buffer_reg))
        else $error("write collision not flagged");
    a_pins_free: assert property (!en |=> !serial_data_line_oe && !serial_clock_line_oe)
        else $error("pins driven while disabled");

    c_spi_xfer: cover property (spi_done);
    c_stop_ok: cover property (stop_done);
    c_stop_coll: cover property (stop_coll);
    c_write_collision_flag: cover property (buf_wr && busy);
endmodule : ssp_port

/* File: ssp_bus_model.sv */
// Far side of the port: pulled-up open-drain lines, a rival master, an SPI echo
`timescale 1ns/1ps
module ssp_bus_model (
    input wire logic data_oe,
    input wire logic data_out,
    input wire logic clock_oe,
    input wire logic hold_data_low,
    input wire logic hold_clock_low,
    output logic sda,
    output logic scl,
    output logic miso
);
    // Pull-ups win unless a party pulls low; the rival can keep either line low
    assign sda = !(data_oe || hold_data_low);
    assign scl = !(clock_oe || hold_clock_low);
    // A released line shows the inverse, so a stale value cannot pass as data
    assign miso = data_oe ? data_out : !data_out;
endmodule : ssp_bus_model

/* File: sync_serial_port_brg_stop_arb_tb.sv */
// Self-checking bench for the serial port: registers, Stop sequence, SPI transfers
`timescale 1ns/1ps
module sync_serial_port_brg_stop_arb_tb;
    logic ref_clk, srst, rd, wr, wq, hold, hclk, sda, scl, miso, dout, doe, cout, coe, own, smb;
    logic [4:0] adr;
    logic [31:0] wd, rdat;
    logic [7:0] q, tx;
    logic [7:0] exp_q[$];
    int fails, tests_run;
    ssp_port dut (.ref_clk(ref_clk), .srst(srst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wq), .serial_data_line_in(sda), .serial_data_line_out(dout),
        .serial_data_line_oe(doe), .serial_clock_line_in(scl), .serial_clock_line_out(cout),
        .serial_clock_line_oe(coe), .spi_data_in_pin(miso), .port_pins_owned(own),
        .smbus_levels(smb));
    ssp_bus_model far (.data_oe(doe), .data_out(dout), .clock_oe(coe),
        .hold_data_low(hold), .hold_clock_low(hclk), .sda(sda), .scl(scl), .miso(miso));
    // Clock at 50 MHz
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // One Avalon access; request held until waitrequest is sampled low
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h000000, d};
        @(posedge ref_clk);
        while (wq !== 1'b0) @(posedge ref_clk);
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Bounded polling of a register until a bit under the mask is set
    task poll(input logic [4:0] a, input logic [7:0] m);
        q = 8'h00;
        for (int i = 0; i < 200 && (q & m) == 8'h00; i++) bus(1'b0, a, 8'h00);
    endtask : poll
    task complete_run;
        $display("tests %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        fails++;
        complete_run();
    end
    initial begin
        {srst, rd, wr, hold, hclk, adr, wd} = {1'b1, 4'h0, 5'h00, 32'h00000000};
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        void'($urandom(32'h7077));
        bus(1'b0, ssp_pkg::OFS_CTRL1, 8'h00);
        chk("ctrl1", ssp_pkg::CTRL1_RST, q);
        bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        chk("status", ssp_pkg::STATUS_RST, q);
        bus(1'b0, 5'h18, 8'h00);
        chk("unmapped", 8'h00, q);
        $display("test reset done");
        bus(1'b1, ssp_pkg::OFS_RELOAD, 8'h03);
        bus(1'b1, ssp_pkg::OFS_CTRL1, {4'h2, ssp_pkg::MODE_I2C_MASTER});
        bus(1'b1, ssp_pkg::OFS_STATUS, 8'h40);
        // The level output is registered, so let it settle first
        repeat (2) @(posedge ref_clk);
        chk("smbus", 8'h01, smb);
        chk("owned", 8'h01, own);
        bus(1'b1, ssp_pkg::OFS_CTRL2, 8'h04);
        poll(ssp_pkg::OFS_FLAGS, 8'h03);
        chk("flags", 8'h01, q);
        bus(1'b0, ssp_pkg::OFS_CTRL2, 8'h00);
        chk("stop_req", 8'h00, q[ssp_pkg::C2_STOP_REQ]);
        bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        chk("stop_seen", 8'h01, q[ssp_pkg::ST_STOP]);
        bus(1'b1, ssp_pkg::OFS_FLAGS, 8'h03);
        $display("test stop done");
        // Rival master keeps data low through the Stop
        hold <= 1'b1;
        bus(1'b1, ssp_pkg::OFS_CTRL2, 8'h04);
        poll(ssp_pkg::OFS_FLAGS, 8'h02);
        chk("bcol", 8'h01, q[ssp_pkg::FL_BCOL]);
        bus(1'b0, ssp_pkg::OFS_CTRL2, 8'h00);
        chk("abort_req", 8'h00, q);
        chk("released", 8'h00, {doe, coe});
        hold <= 1'b0;
        bus(1'b1, ssp_pkg::OFS_FLAGS, 8'h03);
        // Rival pulls the clock low while the released clock is being timed
        bus(1'b1, ssp_pkg::OFS_CTRL2, 8'h04);
        repeat (12) @(posedge ref_clk);
        hclk <= 1'b1;
        poll(ssp_pkg::OFS_FLAGS, 8'h02);
        hclk <= 1'b0;
        chk("bcol_clk", 8'h01, q[ssp_pkg::FL_BCOL]);
        bus(1'b1, ssp_pkg::OFS_FLAGS, 8'h03);
        bus(1'b1, ssp_pkg::OFS_CTRL1, 8'h08);
        bus(1'b0, ssp_pkg::OFS_STATUS, 8'h00);
        chk("seen_off", 8'h00, q[4:3]);
        chk("owned_off", 8'h00, own);
        $display("test collision done");
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, ssp_pkg::OFS_STATUS, {k[0], k[0], 6'h00});
            bus(1'b1, ssp_pkg::OFS_CTRL1, {2'b00, 1'b1, k[0], ssp_pkg::MODE_SPI_DIV16});
            tx = 8'($urandom);
            exp_q.push_back(tx);
            bus(1'b1, ssp_pkg::OFS_BUFFER, tx);
            bus(1'b1, ssp_pkg::OFS_BUFFER, ~tx);
            poll(ssp_pkg::OFS_STATUS, 8'h01);
            bus(1'b0, ssp_pkg::OFS_BUFFER, 8'h00);
            chk("rx", exp_q.pop_front(), q);
            bus(1'b0, ssp_pkg::OFS_CTRL1, 8'h00);
            chk("write_collision_flag", 8'h01, q[ssp_pkg::C1_WRITE_COLLISION_FLAG]);
            chk("ovf", 8'h00, q[ssp_pkg::C1_OVF]);
            chk("idle_clk", {7'h00, k[0]}, cout);
            $display("test spi %0d done", k);
        end
        complete_run();
    end
endmodule : sync_serial_port_brg_stop_arb_tb
